//--- src/serial_control_two.sv
//----------------------------------------------------------------------
// Purpose: Control register two of an async serial port: interrupt
//          enables, transmitter and receiver enables, receiver standby,
//          queued idle and break characters, pin handover
// Assumes: BIT_TICK is a one-cycle pulse per bit time from the baud
//          generator; data path flags arrive on CORE_CLK
// Notes:   How it works list follows
//----------------------------------------------------------------------
// How it works
// [RL1] Control register reads and writes are accepted at any time.
// [RL2] Transmit-done enable set requests interrupt while done flag is one.
// [RL3] Receive enable set requests interrupt while buffer-full flag is one.
// [RL4] Transmitter on drives the transmit pin as a serial output.
// [RL5] Single-wire mode: direction bit decides whether transmit pin drives.
// [RL6] Transmitter off then on while busy queues one idle character.
// [RL7] Pin stays driven until pending data, idle or break has finished.
// [RL8] Receiver enable switches receiver; off releases receive pin.
// [RL9] Loopback always releases the receive pin.
// [RL10] Writing one to standby control parks receiver awaiting wakeup.
// [RL11] Wakeup is idle line, or address mark when mark select is one.
// [RL12] Hardware clears standby control when the wakeup condition occurs.
// [RL13] Break control written one then zero queues one break.
// [RL14] Break is 10/11 bit times low, 13/14 long; repeats while set.
// [RL15] A second break may be queued before software clears the control.
// [RL16] Transmit-done flag is one after reset and when fully idle.
// [RL17] Transmit-empty enable requests interrupt while empty flag is one.
// [RL18] Quiet-line enable requests interrupt while idle flag is one.
//----------------------------------------------------------------------
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

module serial_control_two
(
   input  wire logic                                CORE_CLK,
   input  wire logic                                NRST,
   input  wire logic                                PSEL,
   input  wire logic                                PENABLE,
   input  wire logic                                PWRITE,
   input  wire logic [serial_ctrl_pkg::ADDR_W-1:0]  PADDR,
   input  wire logic [serial_ctrl_pkg::DATA_W-1:0]  PWDATA,
   output      logic [serial_ctrl_pkg::DATA_W-1:0]  PRDATA,
   output      logic                                PREADY,
   output      logic                                PSLVERR,
   input  wire logic                                BIT_TICK,
   input  wire logic                                TX_BUFFER_EMPTY,
   input  wire logic                                TX_DATA_BUSY,
   input  wire logic                                TX_DATA_BIT,
   input  wire logic                                RX_BUFFER_FULL,
   input  wire logic                                LINE_QUIET,
   input  wire logic                                RX_IDLE_SEEN,
   input  wire logic                                RX_MARK_SEEN,
   input  wire logic                                TXD_IN,
   output      logic                                TXD_OUT,
   output      logic                                TXD_OE_N,
   output      logic                                TXD_LINE,
   output      logic                                RXD_OWNED,
   output      logic                                RX_ENABLE,
   output      logic                                RX_STANDBY,
   output      logic                                RX_FROM_TXD,
   output      logic                                TX_DONE,
   output      logic [3:0]                          FLAG_IRQ,
   output      logic                                IRQ
);
   import serial_ctrl_pkg::*;

   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   ctrl2_type           ctrl_ff;
   ctrl2_type           wr_fields;
   cfg_type             cfg_ff;
   logic [EVT_W-1:0]    evt_ff;
   logic [EVT_W-1:0]    mask_ff;
   logic [DATA_W-1:0]   rdata_ff;
   logic                slverr_ff;
   tx_state_type        state_ff;
   logic [3:0]          bit_cnt_ff;
   logic                idle_pend_ff;
   logic                brk_pend_ff;
   logic                tc_ff;
   logic                txd_ff;
   logic                oe_n_ff;
   logic [3:0]          flag_req_ff;
   logic                txd_s1_ff;
   logic                txd_s2_ff;
   logic                access;
   logic                wr_ctrl;
   logic                wr_cfg;
   logic                wr_evt;
   logic                wr_mask;
   logic                te_rise;
   logic                sbk_rise;
   logic                wake_hit;
   logic                single_wire;
   logic                tx_active;
   logic                pin_owned;
   logic                tick_last;
   logic                start_idle;
   logic                start_brk;
   logic                idle_done;
   logic                brk_done;
   logic                nxt_tc;
   logic [3:0]          brk_len;
   logic [3:0]          idle_len;
   logic [DATA_W-1:0]   nxt_rdata;
   logic [EVT_W-1:0]    evt_in;

   //-------------------------------------------------------------------
   // Helpers
   //-------------------------------------------------------------------
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == ADDR_CTRL2) || (a == ADDR_CFG) ||
                  (a == ADDR_STAT)  || (a == ADDR_EVT) ||
                  (a == ADDR_MASK);
   endfunction

   function automatic logic [3:0] char_len(input logic nine,
                                           input logic longer);
      char_len = CHAR_BITS + (nine ? NINTH_BIT : 4'h0)
                 + (longer ? LONG_EXTRA : 4'h0);
   endfunction

   //-------------------------------------------------------------------
   // APB slave
   //-------------------------------------------------------------------
   // Zero wait states; read data is captured in the setup cycle so that
   // PRDATA comes straight from flip-flops.
   assign access  = PSEL && PENABLE;
   assign PREADY  = 1'b1;                                        // RL1
   assign wr_ctrl = access && PWRITE && (PADDR == ADDR_CTRL2);   // RL1
   assign wr_cfg  = access && PWRITE && (PADDR == ADDR_CFG);
   assign wr_evt  = access && PWRITE && (PADDR == ADDR_EVT);
   assign wr_mask = access && PWRITE && (PADDR == ADDR_MASK);
   assign PRDATA  = rdata_ff;
   assign PSLVERR = slverr_ff;

   always_comb
   begin
      nxt_rdata = '0;
      case (PADDR)
         ADDR_CTRL2: nxt_rdata[7:0] = ctrl_ff;                   // RL1
         ADDR_CFG:   nxt_rdata[7:0] = cfg_ff;
         ADDR_STAT:  nxt_rdata[7:0] = {state_ff == ST_BREAK,
                                       state_ff == ST_IDLE_CHAR,
                                       brk_pend_ff, idle_pend_ff,
                                       pin_owned, RXD_OWNED,
                                       tc_ff, TX_BUFFER_EMPTY};
         ADDR_EVT:   nxt_rdata[EVT_W-1:0] = evt_ff;
         ADDR_MASK:  nxt_rdata[EVT_W-1:0] = mask_ff;
         default:    nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
      begin
         rdata_ff  <= '0;
         slverr_ff <= 1'b0;
      end
      else if (PSEL && !PENABLE)
      begin
         rdata_ff  <= PWRITE ? '0 : nxt_rdata;
         slverr_ff <= !is_mapped(PADDR);
      end
   end

   //-------------------------------------------------------------------
   // Control and configuration registers
   //-------------------------------------------------------------------
   assign wr_fields = ctrl2_type'(PWDATA[7:0]);
   assign te_rise  = wr_ctrl && wr_fields.transmitter_on &&
                     !ctrl_ff.transmitter_on;
   assign sbk_rise = wr_ctrl && wr_fields.break_send_ctrl &&
                     !ctrl_ff.break_send_ctrl;
   assign wake_hit = ctrl_ff.rx_standby_ctrl &&
                     (cfg_ff.wake_on_mark ? RX_MARK_SEEN
                                          : RX_IDLE_SEEN);       // RL11

   // A software write wins over a wakeup in the same cycle, so a fresh
   // request for standby is never lost.
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         ctrl_ff <= ctrl2_type'(CTRL2_RST);
      else if (wr_ctrl)
         ctrl_ff <= ctrl2_type'(PWDATA[7:0]);                    // RL10
      else if (wake_hit)
         ctrl_ff.rx_standby_ctrl <= 1'b0;                        // RL12
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         cfg_ff <= cfg_type'(CFG_RST);
      else if (wr_cfg)
         cfg_ff <= cfg_type'(PWDATA[7:0]);
   end

   //-------------------------------------------------------------------
   // Idle and break queue
   //-------------------------------------------------------------------
   assign brk_len    = char_len(cfg_ff.nine_bit_mode,
                                cfg_ff.long_break_select);       // RL14
   assign idle_len   = char_len(cfg_ff.nine_bit_mode, 1'b0);
   assign tick_last  = BIT_TICK && (bit_cnt_ff == CNT_LAST);
   assign idle_done  = (state_ff == ST_IDLE_CHAR) && tick_last;
   assign brk_done   = (state_ff == ST_BREAK) && tick_last;
   // Queued characters wait for the data shifter and a bit boundary
   assign start_idle = (state_ff == ST_QUIET) && BIT_TICK &&
                       !TX_DATA_BUSY && idle_pend_ff;
   assign start_brk  = (state_ff == ST_QUIET) && BIT_TICK &&
                       !TX_DATA_BUSY && !idle_pend_ff && brk_pend_ff;

   // Set wins over the clear made by starting the character
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         idle_pend_ff <= 1'b0;
      else if (te_rise)
         idle_pend_ff <= 1'b1;                                   // RL6
      else if (start_idle)
         idle_pend_ff <= 1'b0;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         brk_pend_ff <= 1'b0;
      else if (sbk_rise)
         brk_pend_ff <= 1'b1;                                    // RL13
      else if (brk_done && ctrl_ff.break_send_ctrl)
         brk_pend_ff <= 1'b1;                                    // RL15
      else if (start_brk)
         brk_pend_ff <= 1'b0;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
      begin
         state_ff   <= ST_QUIET;
         bit_cnt_ff <= '0;
      end
      else
      begin
         case (state_ff)
            ST_QUIET:
            begin
               if (start_idle)
               begin
                  state_ff   <= ST_IDLE_CHAR;
                  bit_cnt_ff <= idle_len;
               end
               else if (start_brk)
               begin
                  state_ff   <= ST_BREAK;
                  bit_cnt_ff <= brk_len;                         // RL14
               end
            end
            ST_IDLE_CHAR, ST_BREAK:
            begin
               if (tick_last)
                  state_ff <= ST_QUIET;
               else if (BIT_TICK)
                  bit_cnt_ff <= bit_cnt_ff - CNT_LAST;
            end
            default:
               state_ff <= ST_QUIET;
         endcase
      end
   end

   //-------------------------------------------------------------------
   // Transmit pin and done flag
   //-------------------------------------------------------------------
   assign single_wire = cfg_ff.loopback_select && cfg_ff.rx_source_select;
   assign tx_active   = (state_ff != ST_QUIET) || TX_DATA_BUSY ||
                        idle_pend_ff || brk_pend_ff;
   // Pin is kept until all queued traffic has drained
   assign pin_owned   = ctrl_ff.transmitter_on || tx_active; // RL4 RL7
   assign nxt_tc      = TX_BUFFER_EMPTY && !tx_active;           // RL16

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
      begin
         txd_ff  <= 1'b1;
         oe_n_ff <= 1'b1;
      end
      else
      begin
         txd_ff  <= (state_ff == ST_BREAK) ? 1'b0 :
                    (TX_DATA_BUSY ? TX_DATA_BIT : 1'b1);
         oe_n_ff <= !(pin_owned &&
                      !(single_wire &&
                        !cfg_ff.single_wire_direction));     // RL5 RL7
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         tc_ff <= 1'b1;                                          // RL16
      else
         tc_ff <= nxt_tc;
   end

   // Shared line read back for the receiver in single-wire mode
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
      begin
         txd_s1_ff <= 1'b1;
         txd_s2_ff <= 1'b1;
      end
      else
      begin
         txd_s1_ff <= TXD_IN;
         txd_s2_ff <= txd_s1_ff;
      end
   end

   assign TXD_OUT     = txd_ff;
   assign TXD_OE_N    = oe_n_ff;
   assign TXD_LINE    = txd_s2_ff;
   assign TX_DONE     = tc_ff;
   assign RX_ENABLE   = ctrl_ff.receiver_on;                     // RL8
   assign RXD_OWNED   = ctrl_ff.receiver_on &&
                        !cfg_ff.loopback_select;             // RL8 RL9
   assign RX_STANDBY  = ctrl_ff.rx_standby_ctrl;                 // RL10
   assign RX_FROM_TXD = cfg_ff.loopback_select;

   //-------------------------------------------------------------------
   // Flag interrupt requests
   //-------------------------------------------------------------------
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         flag_req_ff <= '0;
      else
      begin
         flag_req_ff[REQ_TXEMPTY] <= ctrl_ff.tx_empty_irq_en &&
                                     TX_BUFFER_EMPTY;            // RL17
         flag_req_ff[REQ_TXDONE]  <= ctrl_ff.tx_done_irq_en &&
                                     tc_ff;                      // RL2
         flag_req_ff[REQ_RXFULL]  <= ctrl_ff.rx_full_irq_en &&
                                     RX_BUFFER_FULL;             // RL3
         flag_req_ff[REQ_QUIET]   <= ctrl_ff.line_quiet_irq_en &&
                                     LINE_QUIET;                 // RL18
      end
   end

   assign FLAG_IRQ = flag_req_ff;

   //-------------------------------------------------------------------
   // Sticky events and mask
   //-------------------------------------------------------------------
   always_comb
   begin
      evt_in              = '0;
      evt_in[EVT_TX_DONE] = nxt_tc && !tc_ff;
      evt_in[EVT_BREAK]   = brk_done;
      evt_in[EVT_IDLE]    = idle_done;
      evt_in[EVT_WAKE]    = wake_hit;
   end

   // New events win over a write-one-to-clear in the same cycle
   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         evt_ff <= EVT_RST;
      else
         evt_ff <= (evt_ff & ~(wr_evt ? PWDATA[EVT_W-1:0] : EVT_RST))
                   | evt_in;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!NRST)
         mask_ff <= EVT_RST;
      else if (wr_mask)
         mask_ff <= PWDATA[EVT_W-1:0];
   end

   assign IRQ = |(evt_ff & mask_ff);

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   property p_ready;
      access |-> PREADY && !(PWRITE && (PADDR == ADDR_CTRL2) && PSLVERR);
   endproperty
   a_ready: assert property (p_ready)                            // RL1
      else $error("control access not accepted");

   property p_tx_done_irq_en;
      ctrl_ff.tx_done_irq_en && tc_ff ##1 ctrl_ff.tx_done_irq_en
      |-> FLAG_IRQ[REQ_TXDONE];
   endproperty
   a_tx_done_irq_en: assert property (p_tx_done_irq_en)                              // RL2
      else $error("done interrupt missing");

   property p_rie;
      !ctrl_ff.rx_full_irq_en |=> !FLAG_IRQ[REQ_RXFULL];
   endproperty
   a_rie: assert property (p_rie)                                // RL3
      else $error("receive interrupt while disabled");

   property p_tie;
      (ctrl_ff.tx_empty_irq_en && TX_BUFFER_EMPTY) |=>
      FLAG_IRQ[REQ_TXEMPTY];
   endproperty
   a_tie: assert property (p_tie)                                // RL17
      else $error("empty interrupt missing");

   property p_line_quiet_irq_en;
      (ctrl_ff.line_quiet_irq_en && LINE_QUIET) |=> FLAG_IRQ[REQ_QUIET];
   endproperty
   a_line_quiet_irq_en: assert property (p_line_quiet_irq_en)                              // RL18
      else $error("quiet line interrupt missing");

   property p_own;
      (ctrl_ff.transmitter_on && !single_wire) |=> !TXD_OE_N;
   endproperty
   a_own: assert property (p_own)                                // RL4
      else $error("transmit pin not driven");

   property p_dir;
      (single_wire && !cfg_ff.single_wire_direction) |=> TXD_OE_N;
   endproperty
   a_dir: assert property (p_dir)                                // RL5
      else $error("single wire driven while receiving");

   property p_idle_q;
      te_rise |=> idle_pend_ff;
   endproperty
   a_idle_q: assert property (p_idle_q)                          // RL6
      else $error("idle character not queued");

   property p_hold;
      (state_ff == ST_BREAK && !single_wire) |=> !TXD_OE_N && !TXD_OUT;
   endproperty
   a_hold: assert property (p_hold)                              // RL7
      else $error("pin released during break");

   property p_rxpin;
      (cfg_ff.loopback_select || !ctrl_ff.receiver_on) |-> !RXD_OWNED;
   endproperty
   a_rxpin: assert property (p_rxpin)                            // RL9
      else $error("receive pin kept");

   property p_wake;
      (wake_hit && !wr_ctrl) |=> !RX_STANDBY;
   endproperty
   a_wake: assert property (p_wake)                              // RL12
      else $error("standby not cleared on wakeup");

   property p_brk_q;
      sbk_rise |=> brk_pend_ff;
   endproperty
   a_brk_q: assert property (p_brk_q)                            // RL13
      else $error("break not queued");

   property p_brk_len;
      start_brk |=> bit_cnt_ff == (cfg_ff.long_break_select ?
                    (cfg_ff.nine_bit_mode ? 4'he : 4'hd) :
                    (cfg_ff.nine_bit_mode ? 4'hb : 4'ha));
   endproperty
   a_brk_len: assert property (p_brk_len)                        // RL14
      else $error("wrong break length");

   property p_tc;
      tx_active |=> !TX_DONE;
   endproperty
   a_tc: assert property (p_tc)                                  // RL16
      else $error("done flag set while active");

   c_break: cover property (start_brk ##[1:300] brk_done);
   c_idle:  cover property (te_rise ##[1:300] idle_done);
   c_wake:  cover property (wake_hit ##1 !RX_STANDBY);
   c_irq:   cover property (!IRQ ##1 IRQ);

endmodule

//--- src/serial_ctrl_pkg.sv
//----------------------------------------------------------------------
// Purpose: Shared constants and types of the serial control block
// Assumes: APB with 32-bit data, 12-bit byte address
// Notes:   Register fields are packed in bit order, msb first
//----------------------------------------------------------------------
package serial_ctrl_pkg;

   //-------------------------------------------------------------------
   // Register map
   //-------------------------------------------------------------------
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;
   localparam logic [11:0] ADDR_CTRL2  = 12'h000;
   localparam logic [11:0] ADDR_CFG    = 12'h004;
   localparam logic [11:0] ADDR_STAT   = 12'h008;
   localparam logic [11:0] ADDR_EVT    = 12'h00c;
   localparam logic [11:0] ADDR_MASK   = 12'h010;

   localparam logic [7:0]  CTRL2_RST   = 8'h00;
   localparam logic [7:0]  CFG_RST     = 8'h00;
   localparam logic [3:0]  EVT_RST     = 4'h0;

   // serial_control_two, bit 7 down to bit 0
   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_full_irq_en;
      logic line_quiet_irq_en;
      logic transmitter_on;
      logic receiver_on;
      logic rx_standby_ctrl;
      logic break_send_ctrl;
   } ctrl2_type;

   // Line configuration, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] spare;
      logic       nine_bit_mode;
      logic       long_break_select;
      logic       wake_on_mark;
      logic       single_wire_direction;
      logic       rx_source_select;
      logic       loopback_select;
   } cfg_type;

   // Sticky event bits
   localparam int EVT_W       = 4;
   localparam int EVT_TX_DONE = 0;
   localparam int EVT_BREAK   = 1;
   localparam int EVT_IDLE    = 2;
   localparam int EVT_WAKE    = 3;

   // Flag interrupt request bits
   localparam int REQ_QUIET   = 0;
   localparam int REQ_RXFULL  = 1;
   localparam int REQ_TXDONE  = 2;
   localparam int REQ_TXEMPTY = 3;

   //-------------------------------------------------------------------
   // Character lengths in bit times
   //-------------------------------------------------------------------
   localparam logic [3:0] CHAR_BITS   = 4'ha;
   localparam logic [3:0] NINTH_BIT   = 4'h1;
   localparam logic [3:0] LONG_EXTRA  = 4'h3;
   localparam logic [3:0] CNT_LAST    = 4'h1;

   typedef enum logic [1:0] {
      ST_QUIET,
      ST_IDLE_CHAR,
      ST_BREAK
   } tx_state_type;

endpackage

//--- sim/serial_partner.sv
// Purpose: Remote node model: bit ticks, pin pull-up, low-run meter
// Assumes: Baud ticks every TICK_DIV cycles of the core clock
// Notes:   Low runs are measured in bit ticks seen while the pin is low
`timescale 1ns/100ps
module serial_partner
#(parameter int TICK_DIV = 4)
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       txd_out,
   input  wire logic       txd_oe_n,
   output      logic       bit_tick,
   output      logic       txd_in,
   output      logic [4:0] low_ticks
);
   logic [3:0] div_ff;
   logic [4:0] run_ff;
   // Pull-up: a released pin reads high, never a stale level
   assign txd_in   = txd_oe_n ? 1'b1 : txd_out;
   assign bit_tick = (div_ff == 4'h0);
   always_ff @(posedge clk)
      if (!nrst)
         div_ff <= 4'h0;
      else
         div_ff <= (div_ff == 4'(TICK_DIV - 1)) ? 4'h0 : div_ff + 4'h1;
   always_ff @(posedge clk)
      if (!nrst)
         run_ff <= 5'h00;
      else if (txd_in)
         run_ff <= 5'h00;
      else if (bit_tick)
         run_ff <= run_ff + 5'h01;
   always_ff @(posedge clk)
      if (!nrst)
         low_ticks <= 5'h00;
      else if (txd_in && run_ff != 5'h00)
         low_ticks <= run_ff;
endmodule

//--- sim/testbench.sv
// Purpose: Self-checking bench of the serial control register block
// Assumes: APB master, partner ticks every 4 cycles
// Notes:   Outputs are sampled on the falling edge to avoid races; APB read data and error just after the rising edge
`timescale 1ns/100ps
module testbench;
   import serial_ctrl_pkg::*;
   logic        core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, tx_empty = 1'b1, rx_full = 1'b1;
   logic        quiet = 1'b1, idle_seen = 1'b0, mark_seen = 1'b0, err;
   logic        pready, pslverr, tick, txd_in, txd_out, txd_oe_n, irq;
   logic        rxd_owned, rx_standby, tx_done, rx_enable, rx_from_txd;
   logic        txd_line, busy = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  flag_irq;
   logic [4:0]  low_ticks;
   int          n_errors = 0, tests_run = 0;
   serial_control_two i_serial_control_two (.CORE_CLK(core_clk),
      .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BIT_TICK(tick), .TX_BUFFER_EMPTY(tx_empty),
      .TX_DATA_BUSY(busy), .TX_DATA_BIT(1'b1), .RX_BUFFER_FULL(rx_full),
      .LINE_QUIET(quiet), .RX_IDLE_SEEN(idle_seen),
      .RX_MARK_SEEN(mark_seen), .TXD_IN(txd_in), .TXD_OUT(txd_out),
      .TXD_OE_N(txd_oe_n), .TXD_LINE(txd_line), .RXD_OWNED(rxd_owned),
      .RX_ENABLE(rx_enable), .RX_STANDBY(rx_standby),
      .RX_FROM_TXD(rx_from_txd),
      .TX_DONE(tx_done), .FLAG_IRQ(flag_irq), .IRQ(irq));
   serial_partner i_serial_partner (.clk(core_clk), .nrst(nrst),
      .txd_out(txd_out), .txd_oe_n(txd_oe_n), .bit_tick(tick),
      .txd_in(txd_in), .low_ticks(low_ticks));
   initial
      forever #50 core_clk = ~core_clk;
   //-------------------------------------------------------------------
   // Bus, compare and wait tasks
   //-------------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
         @(posedge core_clk);
      while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wait_done;
      int i;
      i = 0;
      while (tx_done !== 1'b1 && i < 400)
      begin
         @(negedge core_clk);
         i++;
      end
      step(2);
   endtask
   task automatic brk(input int lo);
      apb(1, ADDR_CTRL2, 32'h1);
      apb(1, ADDR_CTRL2, 32'h0);
      step(6);
      chk({txd_oe_n, txd_line}, 2'b00);
      wait_done;
      chk(32'(low_ticks >= lo && low_ticks <= lo + 1), 1);
      apb(0, ADDR_STAT, 0);
      chk(rd, 32'h3);
      chk(txd_oe_n, 1);
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      final_report;
   end
   initial
   begin
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      chk(tx_done, 1);
      apb(0, ADDR_CTRL2, 0);
      chk(rd, 32'(CTRL2_RST));
      for (int i = 0; i < 4; i++)
      begin
         apb(1, ADDR_CTRL2, 32'h10 << i);
         step(2);
         chk(flag_irq, 32'h1 << i);
      end
      apb(1, ADDR_CTRL2, 32'hf0);
      rx_full <= 1'b0;
      step(2);
      chk(flag_irq, 4'hd);
      @(posedge core_clk);
      tx_empty <= 1'b0;
      step(3);
      chk({tx_done, flag_irq}, 5'h01);
      @(posedge core_clk);
      tx_empty <= 1'b1;
      apb(0, ADDR_CTRL2, 0);
      chk(rd, 32'hf0);
      $display("test irq enables done");
      apb(1, ADDR_CTRL2, 32'h04);
      step(2);
      chk(rxd_owned, 1);
      apb(1, ADDR_CFG, 32'h03);
      apb(1, ADDR_CTRL2, 32'h0c);
      step(2);
      chk({rx_enable, rx_from_txd, rxd_owned, txd_oe_n}, 4'hd);
      apb(1, ADDR_CFG, 32'h07);
      step(2);
      chk(txd_oe_n, 0);
      apb(1, ADDR_CFG, 32'h00);
      apb(1, ADDR_CTRL2, 32'h0);
      step(1);
      chk({txd_oe_n, tx_done}, 2'b00);
      wait_done;
      chk(txd_oe_n, 1);
      apb(1, ADDR_CTRL2, 32'h08);
      busy <= 1'b1;
      apb(1, ADDR_CTRL2, 32'h0);
      step(60);
      chk({txd_oe_n, tx_done}, 2'b00);
      @(posedge core_clk);
      busy <= 1'b0;
      wait_done;
      chk(txd_oe_n, 1);
      $display("test pins done");
      for (int w = 0; w < 2; w++)
      begin
         apb(1, ADDR_CFG, 32'(w) << 3);
         apb(1, ADDR_CTRL2, 32'h02);
         {mark_seen, idle_seen} <= w ? 2'b01 : 2'b10;
         @(posedge core_clk);
         {mark_seen, idle_seen} <= 2'b00;
         step(2);
         chk(rx_standby, 1);
         @(posedge core_clk);
         {mark_seen, idle_seen} <= w ? 2'b10 : 2'b01;
         @(posedge core_clk);
         {mark_seen, idle_seen} <= 2'b00;
         step(2);
         chk(rx_standby, 0);
      end
      $display("test standby done");
      apb(1, ADDR_CFG, 32'h0);
      apb(1, ADDR_MASK, 32'h2);
      brk(10);
      chk(irq, 1);
      apb(1, ADDR_EVT, 32'h2);
      step(1);
      chk(irq, 0);
      apb(1, ADDR_CFG, 32'h10);
      brk(13);
      apb(1, ADDR_CFG, 32'h30);
      brk(13);
      apb(0, 12'h020, 0);
      chk({rd[31:1], err}, 32'h1);
      $display("test break done");
      final_report;
   end
endmodule
